// ### decode_pkg.sv
// Purpose: Shared constants and types for the prebyte and opcode decoder
// Assumes: 8-bit instruction bytes, 16-bit program counter
// Notes: Opcode map below is a compact legal set; codes outside it are illegal
package decode_pkg;

  localparam logic [7:0] PRE_X_TO_Y = 8'h90;
  localparam logic [7:0] PRE_IND_X_TO_Y = 8'h91;
  localparam logic [7:0] PRE_MAKE_IND = 8'h92;

  localparam int unsigned INSN_COUNT = 63;
  localparam int unsigned GROUP_COUNT = 13;
  localparam int unsigned MAX_INSN_BYTES = 4;
  localparam int unsigned MAX_OPERAND_BYTES = 2;

  // Addressing modes, from opcode high nibble
  typedef enum logic [3:0] {
    AM_BITDIR = 4'h0,
    AM_BITOP = 4'h1,
    AM_REL = 4'h2,
    AM_SHDIR = 4'h3,
    AM_INH_A = 4'h4,
    AM_SHIDX = 4'h6,
    AM_IDX = 4'h7,
    AM_SYS = 4'h8,
    AM_MISC = 4'h9,
    AM_IMM = 4'hA,
    AM_DIR = 4'hB,
    AM_EXT = 4'hC,
    AM_LIDX = 4'hD,
    AM_SIDX = 4'hE,
    AM_XIDX = 4'hF
  } amode_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_OPC = 7'b0000010,
    S_OPR1 = 7'b0000100,
    S_OPR2 = 7'b0001000,
    S_PTR = 7'b0010000,
    S_PTR2 = 7'b0100000,
    S_DONE = 7'b1000000
  } dstate_t;

  typedef enum logic [1:0] {
    IDX_NONE = 2'h0,
    IDX_X = 2'h1,
    IDX_Y = 2'h2
  } idx_t;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

endpackage : decode_pkg

// ### opcode_class.sv
// Purpose: Classifies one opcode: legality, operand count, mode
// Assumes: Pure combinational, same clock domain as caller
// Notes: Table is a compact legal map of the instruction set
`timescale 1ns/1ps
module opcode_class (
  // Opcode in
  input wire logic [7:0] opc,
  // Classification out
  output logic legal,
  output logic [1:0] n_operands,
  output logic is_rel,
  output logic is_xidx,
  output logic is_bit_rel
);
  import decode_pkg::*;

  logic [3:0] hi;
  logic [3:0] lo;

  always_comb begin
    hi = opc[7:4];
    lo = opc[3:0];
    legal = 1'b1;
    n_operands = 2'd0;
    is_rel = 1'b0;
    is_xidx = 1'b0;
    is_bit_rel = 1'b0;
    case (hi)
      AM_BITDIR: begin
        n_operands = 2'd2;
        is_bit_rel = 1'b1;
      end
      AM_BITOP: n_operands = 2'd1;
      AM_REL: begin
        n_operands = 2'd1;
        is_rel = 1'b1;
      end
      AM_SHDIR: begin
        n_operands = 2'd1;
        legal = (lo != 4'h2) && (lo != 4'h5) && (lo != 4'hB);
      end
      AM_INH_A, 4'h5: legal = (lo != 4'h1) && (lo != 4'h5) && (lo != 4'hB);
      AM_SHIDX: begin
        n_operands = 2'd1;
        is_xidx = 1'b1;
        legal = (lo != 4'h1) && (lo != 4'h5) && (lo != 4'hB);
      end
      AM_IDX: begin
        is_xidx = 1'b1;
        legal = (lo != 4'h1) && (lo != 4'h5) && (lo != 4'hB);
      end
      AM_SYS: legal = (lo == 4'h0) || (lo == 4'h1) || (lo == 4'h3) || (lo == 4'h4)
        || (lo == 4'h5) || (lo == 4'h6) || (lo == 4'h8) || (lo == 4'hE) || (lo == 4'hF);
      AM_MISC: begin
        legal = (lo >= 4'h3);
        n_operands = 2'd0;
      end
      AM_IMM: begin
        n_operands = 2'd1;
        legal = (lo != 4'h7) && (lo != 4'hC);
        is_rel = (lo == 4'hD);
      end
      AM_DIR: n_operands = 2'd1;
      AM_EXT: n_operands = 2'd2;
      AM_LIDX: begin
        n_operands = 2'd2;
        is_xidx = 1'b1;
      end
      AM_SIDX: begin
        n_operands = 2'd1;
        is_xidx = 1'b1;
      end
      AM_XIDX: is_xidx = 1'b1;
      default: legal = 1'b0;
    endcase
  end

endmodule : opcode_class

// ### prebyte_decoder.sv
// Function
// - Relative target is PC plus sign-extended 8-bit offset.
// - Direct relative takes offset from byte after opcode.
// - Indirect relative reads offset from address in byte after opcode.
// - Instructions span one to four bytes including optional prebyte.
// - Zero to two operand bytes follow opcode per addressing mode.
// - Prebyte sits just before opcode and modifies its meaning.
// - Prebyte 90 switches X-based instruction to Y.
// - Prebyte 92 makes direct, bit or relative forms indirect.
// - Prebyte 92 on X-indexed gives indirect X-indexed.
// - Prebyte 91 turns X indirect indexed into Y indirect indexed.
// - Byte neither opcode nor prebyte raises system reset.
// - Valid prebyte with valid opcode never raises illegal reset.
// - Decoder covers 63 instructions in 13 groups.
// - Short indirect indexed: byte pointer plus index, up to 1FE.
// - Long indirect indexed: word pointer plus index, 64 Kbyte space.
//
// Purpose: Fetch-side decode of prebyte, opcode and operand bytes
// Assumes: Memory answers a read request with byte and valid, any latency
// Notes: Effective address and branch target are held until the next S_DONE cycle
`timescale 1ns/1ps
module prebyte_decoder (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Program memory byte stream
  output logic FETCH_REQ,
  output logic [15:0] FETCH_ADDR,
  input wire logic [7:0] FETCH_DATA,
  input wire logic FETCH_VALID,
  // Control from datapath
  input wire logic START,
  input wire logic [15:0] PC_IN,
  input wire logic [7:0] X_REG,
  input wire logic [7:0] Y_REG,
  // Decoded instruction
  output logic DEC_VALID,
  output logic [7:0] DEC_OPCODE,
  output logic [7:0] DEC_PREBYTE,
  output logic [2:0] DEC_LENGTH,
  output logic [15:0] DEC_EA,
  output logic [15:0] DEC_BRANCH_PC,
  output logic [1:0] DEC_INDEX,
  output logic DEC_INDIRECT,
  output logic [15:0] DEC_NEXT_PC,
  // Reset controller
  output logic ILLEGAL_RESET
);
  import decode_pkg::*;

  dstate_t state_q;
  logic [15:0] pc_q;
  logic [15:0] ptr_addr_q;
  logic [7:0] pre_q;
  logic [7:0] opc_q;
  logic [7:0] opr1_q;
  logic [7:0] opr2_q;
  logic [7:0] ptr_hi_q;
  logic [2:0] len_q;
  logic [1:0] need_q;
  logic long_ptr_q;
  logic illegal_q;
  logic [15:0] ea_q;
  logic [15:0] bpc_q;
  logic valid_q;

  logic legal;
  logic [1:0] n_opr;
  logic is_rel;
  logic is_xidx;
  logic is_bit_rel;

  function automatic logic is_prebyte(input logic [7:0] b);
    is_prebyte = (b == PRE_X_TO_Y) || (b == PRE_IND_X_TO_Y) || (b == PRE_MAKE_IND);
  endfunction : is_prebyte

  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] off);
    rel_target = pc + {{8{off[7]}}, off};
  endfunction : rel_target

  opcode_class u_class (
    .opc(FETCH_DATA),
    .legal(legal),
    .n_operands(n_opr),
    .is_rel(is_rel),
    .is_xidx(is_xidx),
    .is_bit_rel(is_bit_rel)
  );

  logic indirect;
  logic [7:0] idx_val;
  assign indirect = (pre_q == PRE_MAKE_IND) || (pre_q == PRE_IND_X_TO_Y);
  assign idx_val = ((pre_q == PRE_X_TO_Y) || (pre_q == PRE_IND_X_TO_Y)) ? Y_REG : X_REG;

  // ****************************************
  // Fetch sequence
  // ****************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= S_IDLE;
      pc_q <= WORD_ZERO;
      pre_q <= BYTE_ZERO;
      opc_q <= BYTE_ZERO;
      opr1_q <= BYTE_ZERO;
      opr2_q <= BYTE_ZERO;
      ptr_hi_q <= BYTE_ZERO;
      ptr_addr_q <= WORD_ZERO;
      len_q <= 3'd0;
      need_q <= 2'd0;
      long_ptr_q <= 1'b0;
      illegal_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      illegal_q <= 1'b0;
      valid_q <= 1'b0;
      case (state_q)
        S_IDLE: if (START) begin
          pc_q <= PC_IN;
          pre_q <= BYTE_ZERO;
          opr1_q <= BYTE_ZERO;
          opr2_q <= BYTE_ZERO;
          ptr_hi_q <= BYTE_ZERO;
          len_q <= 3'd0;
          state_q <= S_OPC;
        end
        S_OPC: if (FETCH_VALID) begin
          pc_q <= pc_q + 16'h0001;
          len_q <= len_q + 3'd1;
          if (is_prebyte(FETCH_DATA) && pre_q == BYTE_ZERO) begin
            pre_q <= FETCH_DATA;
          end else if (!legal) begin
            illegal_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            opc_q <= FETCH_DATA;
            need_q <= (indirect && n_opr == 2'd2 && !is_bit_rel) ? 2'd1 : n_opr;
            long_ptr_q <= (FETCH_DATA[7:4] == AM_LIDX) || (FETCH_DATA[7:4] == AM_EXT);
            state_q <= (n_opr == 2'd0) ? S_DONE : S_OPR1;
          end
        end
        S_OPR1: if (FETCH_VALID) begin
          pc_q <= pc_q + 16'h0001;
          len_q <= len_q + 3'd1;
          opr1_q <= FETCH_DATA;
          if (indirect && opc_q[7:4] != AM_IMM && (need_q == 2'd1 || is_bit_rel_q)) begin
            ptr_addr_q <= {BYTE_ZERO, FETCH_DATA};
            state_q <= S_PTR;
          end else begin
            state_q <= (need_q == 2'd2) ? S_OPR2 : S_DONE;
          end
        end
        S_OPR2: if (FETCH_VALID) begin
          pc_q <= pc_q + 16'h0001;
          len_q <= len_q + 3'd1;
          opr2_q <= FETCH_DATA;
          state_q <= S_DONE;
        end
        S_PTR: if (FETCH_VALID) begin
          ptr_hi_q <= FETCH_DATA;
          ptr_addr_q <= ptr_addr_q + 16'h0001;
          state_q <= long_ptr_q ? S_PTR2 : (is_bit_rel_q ? S_OPR2 : S_DONE);
        end
        S_PTR2: if (FETCH_VALID) begin
          opr2_q <= FETCH_DATA;
          state_q <= S_DONE;
        end
        S_DONE: begin
          valid_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Address and target forming
  // ****************************************
  logic is_bit_rel_q;
  logic is_xidx_q;
  logic [15:0] base;
  logic [7:0] offset;
  always_comb begin
    base = {BYTE_ZERO, opr1_q};
    offset = opr1_q;
    if (indirect && long_ptr_q) begin
      base = {ptr_hi_q, opr2_q};
    end else if (indirect) begin
      base = {BYTE_ZERO, ptr_hi_q};
    end else if (long_ptr_q) begin
      base = {opr1_q, opr2_q};
    end
    if (is_bit_rel_q) begin
      offset = opr2_q;
    end else if (indirect) begin
      offset = ptr_hi_q;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      is_bit_rel_q <= 1'b0;
      is_xidx_q <= 1'b0;
    end else if (state_q == S_OPC && FETCH_VALID && legal && !is_prebyte(FETCH_DATA)) begin
      is_bit_rel_q <= is_bit_rel;
      is_xidx_q <= is_xidx;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ea_q <= WORD_ZERO;
      bpc_q <= WORD_ZERO;
    end else if (state_q == S_DONE) begin
      ea_q <= is_xidx_q ? base + {BYTE_ZERO, idx_val} : base;
      bpc_q <= rel_target(pc_q, offset);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign FETCH_REQ = (state_q == S_OPC) || (state_q == S_OPR1) || (state_q == S_OPR2)
    || (state_q == S_PTR) || (state_q == S_PTR2);
  assign FETCH_ADDR = ((state_q == S_PTR) || (state_q == S_PTR2)) ? ptr_addr_q : pc_q;
  assign ILLEGAL_RESET = illegal_q;
  assign DEC_VALID = valid_q;
  assign DEC_OPCODE = opc_q;
  assign DEC_PREBYTE = pre_q;
  assign DEC_LENGTH = len_q;
  assign DEC_EA = ea_q;
  assign DEC_BRANCH_PC = bpc_q;
  assign DEC_INDEX = !is_xidx_q ? IDX_NONE
    : (((pre_q == PRE_X_TO_Y) || (pre_q == PRE_IND_X_TO_Y)) ? IDX_Y : IDX_X);
  assign DEC_INDIRECT = indirect;
  assign DEC_NEXT_PC = pc_q;

endmodule : prebyte_decoder

// ### dec_checker.sv
// Purpose: Port checks for the decoder
// Assumes: One clock, async active-low reset
// Notes: Bound to every decoder instance
`timescale 1ns/1ps
module dec_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Fetch and start
  input wire logic FETCH_REQ,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic [7:0] FETCH_DATA,
  input wire logic FETCH_VALID,
  input wire logic START,
  input wire logic [15:0] PC_IN,
  // Results
  input wire logic DEC_VALID,
  input wire logic [7:0] DEC_OPCODE,
  input wire logic [7:0] DEC_PREBYTE,
  input wire logic [2:0] DEC_LENGTH,
  input wire logic [15:0] DEC_BRANCH_PC,
  input wire logic [1:0] DEC_INDEX,
  input wire logic DEC_INDIRECT,
  input wire logic [15:0] DEC_NEXT_PC,
  input wire logic ILLEGAL_RESET
);
  import decode_pkg::*;
  logic busy_q;
  logic [15:0] pc_q;
  logic [7:0] byte_q;
  // ****
  // Start address and last byte
  // ****
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_q <= 1'h0;
      pc_q <= 16'h0000;
    end else if (START && (!busy_q || DEC_VALID || ILLEGAL_RESET)) begin
      busy_q <= 1'h1;
      pc_q <= PC_IN;
    end else if (DEC_VALID || ILLEGAL_RESET) begin
      busy_q <= 1'h0;
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      byte_q <= 8'h00;
    end else if (FETCH_REQ && FETCH_VALID) begin
      byte_q <= FETCH_DATA;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  illeg_pulse_a: assert property (ILLEGAL_RESET |=> !ILLEGAL_RESET)
    else $error("illegal reset too long");
  illeg_cause_a: assert property (ILLEGAL_RESET |->
    $past(FETCH_REQ && FETCH_VALID) || $past(FETCH_REQ && FETCH_VALID, 2))
    else $error("illegal reset without byte");
  len_range_a: assert property (DEC_VALID |-> DEC_LENGTH inside {[3'h1:3'h4]})
    else $error("length out of range");
  next_pc_a: assert property (DEC_VALID |-> DEC_NEXT_PC == pc_q + 16'(DEC_LENGTH))
    else $error("next pc wrong");
  branch_pc_a: assert property (DEC_VALID && DEC_OPCODE[7:4] == 4'h2 |->
    DEC_BRANCH_PC == DEC_NEXT_PC + {{8{byte_q[7]}}, byte_q})
    else $error("branch target wrong");
  addr_hold_a: assert property (FETCH_REQ && !FETCH_VALID |=>
    FETCH_REQ && $stable(FETCH_ADDR))
    else $error("fetch dropped");
  pre_y_a: assert property (DEC_VALID && DEC_PREBYTE == PRE_X_TO_Y |->
    DEC_INDEX != IDX_X && !DEC_INDIRECT)
    else $error("y prebyte wrong");
  pre_ind_a: assert property (DEC_VALID && DEC_PREBYTE == PRE_MAKE_IND &&
    DEC_OPCODE[7:4] != 4'hA |-> DEC_INDIRECT)
    else $error("indirect prebyte wrong");
  pre_iy_a: assert property (DEC_VALID && DEC_PREBYTE == PRE_IND_X_TO_Y |->
    DEC_INDEX == IDX_Y && DEC_INDIRECT)
    else $error("indirect y prebyte wrong");
endmodule : dec_checker
bind prebyte_decoder dec_checker chk_u (
  .CLK(CLK),
  .RST_B(RST_B),
  .FETCH_REQ(FETCH_REQ),
  .FETCH_ADDR(FETCH_ADDR),
  .FETCH_DATA(FETCH_DATA),
  .FETCH_VALID(FETCH_VALID),
  .START(START),
  .PC_IN(PC_IN),
  .DEC_VALID(DEC_VALID),
  .DEC_OPCODE(DEC_OPCODE),
  .DEC_PREBYTE(DEC_PREBYTE),
  .DEC_LENGTH(DEC_LENGTH),
  .DEC_BRANCH_PC(DEC_BRANCH_PC),
  .DEC_INDEX(DEC_INDEX),
  .DEC_INDIRECT(DEC_INDIRECT),
  .DEC_NEXT_PC(DEC_NEXT_PC),
  .ILLEGAL_RESET(ILLEGAL_RESET)
);

// ### prog_mem.sv
// Purpose: Program memory model for the decoder
// Assumes: One byte per request, valid one cycle
// Notes: Data inverts once, in the cycle after each answer, then holds
`timescale 1ns/1ps
module prog_mem (
  // Clock and fetch
  input wire logic clk,
  input wire logic req,
  input wire logic [15:0] addr,
  output logic [7:0] data,
  output logic vld,
  // Wait cycles
  input wire logic [1:0] slow
);
  logic [7:0] mem [256];
  logic [1:0] wait_q;
  initial begin
    vld = 1'h0;
    data = 8'hA5;
    wait_q = 2'h0;
  end
  // ****
  // Answer
  // ****
  always @(posedge clk) begin
    if (vld) begin
      vld <= 1'h0;
      data <= ~data;
    end else if (req && wait_q == slow) begin
      vld <= 1'h1;
      data <= mem[addr[7:0]];
      wait_q <= 2'h0;
    end else if (req) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : prog_mem

// ### tb_top.sv
// Purpose: Self-checking bench for the decoder
// Assumes: Memory model answers fetches
// Notes: Opcodes from the compact legal map, plus illegal 55 for the reset cases
`timescale 1ns/1ps
module tb_top;
  import decode_pkg::*;
  logic CLK;
  logic RST_B;
  logic START;
  logic [15:0] PC_IN;
  logic [7:0] X_REG;
  logic [7:0] Y_REG;
  logic FETCH_REQ;
  logic [15:0] FETCH_ADDR;
  logic [7:0] FETCH_DATA;
  logic FETCH_VALID;
  logic DEC_VALID;
  logic [7:0] DEC_OPCODE;
  logic [7:0] DEC_PREBYTE;
  logic [2:0] DEC_LENGTH;
  logic [15:0] DEC_EA;
  logic [15:0] DEC_BRANCH_PC;
  logic [1:0] DEC_INDEX;
  logic DEC_INDIRECT;
  logic [15:0] DEC_NEXT_PC;
  logic ILLEGAL_RESET;
  logic [1:0] slow;
  int failures;
  int checks;
  prebyte_decoder dut_u (
    .CLK(CLK),
    .RST_B(RST_B),
    .FETCH_REQ(FETCH_REQ),
    .FETCH_ADDR(FETCH_ADDR),
    .FETCH_DATA(FETCH_DATA),
    .FETCH_VALID(FETCH_VALID),
    .START(START),
    .PC_IN(PC_IN),
    .X_REG(X_REG),
    .Y_REG(Y_REG),
    .DEC_VALID(DEC_VALID),
    .DEC_OPCODE(DEC_OPCODE),
    .DEC_PREBYTE(DEC_PREBYTE),
    .DEC_LENGTH(DEC_LENGTH),
    .DEC_EA(DEC_EA),
    .DEC_BRANCH_PC(DEC_BRANCH_PC),
    .DEC_INDEX(DEC_INDEX),
    .DEC_INDIRECT(DEC_INDIRECT),
    .DEC_NEXT_PC(DEC_NEXT_PC),
    .ILLEGAL_RESET(ILLEGAL_RESET)
  );
  prog_mem mem_u (.clk(CLK), .req(FETCH_REQ), .addr(FETCH_ADDR), .data(FETCH_DATA),
    .vld(FETCH_VALID), .slow(slow));
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end
  // ****
  // Helpers
  // ****
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick;
    @(posedge CLK);
    #1;
  endtask : tick
  task automatic put(input logic [7:0] a, input logic [7:0] b0, b1, b2);
    mem_u.mem[a] = b0;
    mem_u.mem[a + 8'h01] = b1;
    mem_u.mem[a + 8'h02] = b2;
  endtask : put
  task automatic run(input logic [7:0] pc, input logic ill);
    int n;
    PC_IN = {8'h00, pc};
    START = 1'h1;
    tick;
    START = 1'h0;
    n = 0;
    while (DEC_VALID !== 1'h1 && ILLEGAL_RESET !== 1'h1 && n < 40) begin
      tick;
      n++;
    end
    check("valid", DEC_VALID, !ill);
    check("illegal", ILLEGAL_RESET, ill);
  endtask : run
  // ****
  // Scenarios
  // ****
  task automatic s_inh;
    put(8'h10, 8'h4C, 8'h00, 8'h00);
    run(8'h10, 1'h0);
    check("len", DEC_LENGTH, 3'h1);
    check("pre", DEC_PREBYTE, 8'h00);
    check("opc", DEC_OPCODE, 8'h4C);
  endtask : s_inh
  task automatic s_ext;
    put(8'h20, 8'hC6, 8'h12, 8'h34);
    run(8'h20, 1'h0);
    check("len", DEC_LENGTH, 3'h3);
    check("ea", DEC_EA, 16'h1234);
    check("next", DEC_NEXT_PC, 16'h0023);
  endtask : s_ext
  task automatic s_long;
    put(8'h70, 8'h92, 8'hD6, 8'h88);
    put(8'h88, 8'h12, 8'h34, 8'h00);
    run(8'h70, 1'h0);
    check("ea", DEC_EA, 16'h1240);
    check("len", DEC_LENGTH, 3'h3);
  endtask : s_long
  task automatic s_ind_bit;
    put(8'hC0, 8'h92, 8'h03, 8'h8C);
    put(8'hC3, 8'h04, 8'h00, 8'h00);
    put(8'h8C, 8'h50, 8'h00, 8'h00);
    run(8'hC0, 1'h0);
    check("len", DEC_LENGTH, 3'h4);
    check("ea", DEC_EA, 16'h0050);
    check("target", DEC_BRANCH_PC, 16'h00C8);
  endtask : s_ind_bit
  task automatic s_rel;
    slow = 2'h2;
    put(8'h30, 8'h20, 8'hF0, 8'h00);
    run(8'h30, 1'h0);
    slow = 2'h0;
    check("target", DEC_BRANCH_PC, 16'h0022);
  endtask : s_rel
  task automatic s_ind_rel;
    put(8'h40, 8'h92, 8'h20, 8'h80);
    put(8'h80, 8'h05, 8'h00, 8'h00);
    run(8'h40, 1'h0);
    check("target", DEC_BRANCH_PC, 16'h0048);
    check("ind", DEC_INDIRECT, 1'h1);
  endtask : s_ind_rel
  task automatic s_y;
    put(8'h50, 8'h90, 8'hF6, 8'h00);
    run(8'h50, 1'h0);
    check("index", DEC_INDEX, IDX_Y);
    check("ea", DEC_EA, 16'h0021);
  endtask : s_y
  task automatic s_ind_idx(input logic [7:0] pre, input logic [15:0] ea);
    put(8'h60, pre, 8'hE6, 8'h84);
    put(8'h84, 8'hFF, 8'h00, 8'h00);
    run(8'h60, 1'h0);
    check("ea", DEC_EA, ea);
    check("ind", DEC_INDIRECT, 1'h1);
  endtask : s_ind_idx
  task automatic s_combo;
    put(8'hA0, 8'h92, 8'h4C, 8'h00);
    run(8'hA0, 1'h0);
    check("len", DEC_LENGTH, 3'h2);
  endtask : s_combo
  task automatic s_bad(input logic [7:0] b0, input logic [7:0] b1);
    put(8'hB0, b0, b1, 8'h00);
    run(8'hB0, 1'h1);
    tick;
    check("pulse", ILLEGAL_RESET, 1'h0);
    RST_B = 1'h0;
    tick;
    RST_B = 1'h1;
    tick;
  endtask : s_bad
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    #50000;
    failures++;
    complete_run;
  end
  initial begin
    RST_B = 1'h0;
    START = 1'h0;
    PC_IN = 16'h0000;
    X_REG = 8'h0C;
    Y_REG = 8'h21;
    slow = 2'h0;
    repeat (4) @(posedge CLK);
    #1;
    RST_B = 1'h1;
    tick;
    s_inh;
    s_ext;
    s_rel;
    s_ind_rel;
    s_y;
    s_ind_idx(8'h91, 16'h0120);
    s_ind_idx(8'h92, 16'h010B);
    s_combo;
    s_long;
    s_ind_bit;
    s_bad(8'h55, 8'h00);
    s_bad(8'h90, 8'h55);
    s_inh;
    complete_run;
  end
endmodule : tb_top
